// ==== logic/sleep_consts.vh ====
// constants for the low-power state controller: state codes and timing counts
// assumes a 125 MHz sampling clock and a bus clock that runs well below it
`ifndef SLEEP_CONSTS_VH
`define SLEEP_CONSTS_VH

// ----------------------------------------------------------------------------
// power state codes
// ----------------------------------------------------------------------------
`define ST_NORMAL        3'h0
`define ST_HALT          3'h1
`define ST_STOP_GRANT    3'h2
`define ST_SNOOP         3'h3
`define ST_SLEEP         3'h4
`define ST_DEEP_SLEEP    3'h5
`define ST_W             3

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
// 1 ms of settling at the 8 ns sample clock; sized to the counter so
// no bits are dropped; a slower sample clock needs a smaller count
`define SETTLE_CYCLES    17'h1E848
`define SETTLE_W         17
// sample cycles without a bus clock rising edge before the bus clock counts as stopped
`define BUS_STOP_CYCLES  5'h10
`define BUS_STOP_W       5
// reset-low bus clock edges counted in sleep; full reset comes on the edge after this count
`define RESET_HOLD_EDGES 4'hF
`define RESET_HOLD_W     4

`endif

// ==== logic/bus_clock_monitor.v ====
// watches the sampled bus clock: rising-edge strobe and stopped level
// assumes i_bus_clk is synchronous to i_mclk and far slower than it
`timescale 1ns/10ps
`default_nettype none
`include "sleep_consts.vh"

module bus_clock_monitor (
    // clock and reset
    input  wire                   i_mclk,
    input  wire                   i_rst_n,
    // sampled bus clock
    input  wire                   i_bus_clk,
    // status
    output reg                    o_rise,
    output reg                    o_stopped
);

    reg                    last_ff;
    reg [`BUS_STOP_W-1:0]  idle_ff;
    wire                   rise;

    assign rise = i_bus_clk & ~last_ff;

    // ------------------------------------------------------------------------
    // edge detect and stop timeout
    // ------------------------------------------------------------------------
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last_ff   <= 1'b0;
            idle_ff   <= {`BUS_STOP_W{1'b0}};
            o_rise    <= 1'b0;
            o_stopped <= 1'b0;
        end else begin
            last_ff <= i_bus_clk;
            o_rise  <= rise;
            if (rise) begin
                idle_ff   <= {`BUS_STOP_W{1'b0}};
                o_stopped <= 1'b0;
            end else if (idle_ff == `BUS_STOP_CYCLES) begin
                o_stopped <= 1'b1;
            end else begin
                idle_ff <= idle_ff + {{(`BUS_STOP_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // bus_clock_monitor

`default_nettype wire

// ==== logic/pll_settle_timer.v ====
// counts the pll settling wait after the bus clock restarts
// assumes i_run stays high for the whole wait; a drop restarts the count
`timescale 1ns/10ps
`default_nettype none
`include "sleep_consts.vh"

module pll_settle_timer #(
    parameter [`SETTLE_W-1:0] SETTLE_CYCLES = `SETTLE_CYCLES
) (
    // clock and reset
    input  wire                 i_mclk,
    input  wire                 i_rst_n,
    // control
    input  wire                 i_run,
    // status
    output reg                  o_done
);

    reg [`SETTLE_W-1:0] count_ff;

    // ------------------------------------------------------------------------
    // settle counter
    // ------------------------------------------------------------------------
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_ff <= {`SETTLE_W{1'b0}};
            o_done   <= 1'b0;
        end else if (!i_run) begin
            count_ff <= {`SETTLE_W{1'b0}};
            o_done   <= 1'b0;
        end else if (count_ff >= SETTLE_CYCLES - 1'b1) begin
            o_done <= 1'b1;
        end else begin
            count_ff <= count_ff + {{(`SETTLE_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // pll_settle_timer

`default_nettype wire

// ==== logic/sleep_state_clock_control.v ====
// low-power state controller: normal, halt, stop-grant, snoop, sleep, deep sleep
// assumes all request pins are synchronous to i_mclk and that the bus clock
// arrives as a sampled input; the chipset keeps its own side of the protocol
`timescale 1ns/10ps
`default_nettype none
`include "sleep_consts.vh"

module sleep_state_clock_control #(
    parameter [`SETTLE_W-1:0] SETTLE_CYCLES = `SETTLE_CYCLES
) (
    // clock and reset
    input  wire                 i_mclk,
    input  wire                 i_rst_n,
    // bus clock, sampled
    input  wire                 i_bus_clk,
    // power-management requests from the chipset
    input  wire                 i_sleep_request_n,
    input  wire                 i_stop_clock_request_n,
    input  wire                 i_bus_reset_n,
    // core events
    input  wire                 i_halt_exec,
    input  wire                 i_wake_event,
    input  wire                 i_irq_event,
    input  wire                 i_irq_ack,
    // snoop traffic
    input  wire                 i_snoop_start,
    input  wire                 i_snoop_done,
    // state and clock enables
    output reg  [`ST_W-1:0]     o_state,
    output reg                  o_core_clk_en,
    output reg                  o_pll_lock_hold,
    output reg                  o_l2_clk_en,
    output reg                  o_snoop_en,
    output reg                  o_irq_latch_en,
    output reg                  o_interrupt_controller_clock_req,
    // events
    output reg                  o_irq_pending,
    output reg                  o_full_reset,
    output reg                  o_bus_edge
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    reg  [`ST_W-1:0]         nxt_state;
    reg                      from_halt_ff;
    reg                      nxt_from_halt;
    reg  [`RESET_HOLD_W-1:0] rst_hold_ff;
    reg  [`RESET_HOLD_W-1:0] nxt_rst_hold;
    reg                      nxt_full_reset;
    reg                      sleep_req_ff;
    reg                      stop_req_ff;
    reg                      bus_rst_ff;
    reg                      snoop_start_ff;
    reg                      snoop_done_ff;
    wire                     bus_rise;
    wire                     bus_stopped;
    wire                     settle_done;
    wire                     settle_run;
    wire                     asleep;
    wire                     irq_take;

    // ------------------------------------------------------------------------
    // bus clock watch and pll settling
    // ------------------------------------------------------------------------
    bus_clock_monitor u_bus_clock_monitor (
        .i_mclk    (i_mclk),
        .i_rst_n   (i_rst_n),
        .i_bus_clk (i_bus_clk),
        .o_rise    (bus_rise),
        .o_stopped (bus_stopped)
    );

    assign settle_run = (o_state == `ST_DEEP_SLEEP) && !bus_stopped;

    pll_settle_timer #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_pll_settle_timer (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (settle_run),
        .o_done  (settle_done)
    );

    assign asleep = (o_state == `ST_SLEEP) || (o_state == `ST_DEEP_SLEEP);

    // ------------------------------------------------------------------------
    // bus-side sampling
    // ------------------------------------------------------------------------
    // sample on rising edge
    // requests only move on a bus clock rising edge, so a pulse shorter
    // than one bus period may be missed; the chipset holds them longer
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sleep_req_ff   <= 1'b0;
            stop_req_ff    <= 1'b0;
            bus_rst_ff     <= 1'b0;
            snoop_start_ff <= 1'b0;
            snoop_done_ff  <= 1'b0;
        end else if (bus_rise) begin
            sleep_req_ff   <= ~i_sleep_request_n;
            stop_req_ff    <= ~i_stop_clock_request_n;
            bus_rst_ff     <= ~i_bus_reset_n;
            snoop_start_ff <= i_snoop_start;
            snoop_done_ff  <= i_snoop_done;
        end else begin
            snoop_start_ff <= 1'b0;
            snoop_done_ff  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always @* begin
        nxt_state      = o_state;
        nxt_from_halt  = from_halt_ff;
        nxt_rst_hold   = rst_hold_ff;
        nxt_full_reset = 1'b0;
        case (o_state)
            `ST_NORMAL: begin
                if (bus_rst_ff && bus_rise) begin
                    nxt_full_reset = 1'b1;
                end else if (stop_req_ff) begin
                    nxt_state     = `ST_STOP_GRANT;
                    nxt_from_halt = 1'b0;
                end else if (i_halt_exec) begin
                    nxt_state = `ST_HALT;
                end
            end
            `ST_HALT: begin
                if (bus_rst_ff && bus_rise) begin
                    nxt_state      = `ST_NORMAL;
                    nxt_full_reset = 1'b1;
                end else if (snoop_start_ff) begin
                    nxt_state     = `ST_SNOOP;
                    nxt_from_halt = 1'b1;
                end else if (stop_req_ff) begin
                    nxt_state     = `ST_STOP_GRANT;
                    nxt_from_halt = 1'b1;
                end else if (i_wake_event) begin
                    nxt_state = `ST_NORMAL;
                end
            end
            `ST_STOP_GRANT: begin
                // reset here reinitialises but keeps stop-grant
                if (bus_rst_ff && bus_rise) begin
                    nxt_full_reset = 1'b1;
                    nxt_from_halt  = 1'b0;
                end else if (snoop_start_ff) begin
                    nxt_state = `ST_SNOOP;
                end else if (sleep_req_ff) begin
                    nxt_state    = `ST_SLEEP;
                    nxt_rst_hold = {`RESET_HOLD_W{1'b0}};
                end else if (!stop_req_ff) begin
                    nxt_state = from_halt_ff ? `ST_HALT : `ST_NORMAL;
                end
            end
            `ST_SNOOP: begin
                // the snoop returns to halt when from_halt_ff is set and no stop request is held, else to stop-grant
                if (snoop_done_ff) begin
                    if (from_halt_ff && !stop_req_ff) begin
                        nxt_state = `ST_HALT;
                    end else begin
                        nxt_state     = `ST_STOP_GRANT;
                        nxt_from_halt = from_halt_ff && stop_req_ff;
                    end
                end
            end
            `ST_SLEEP: begin
                // stopped clock is deep sleep
                // seen only after the stop timeout, so a clock held low
                // for less than that counts as slow, not stopped
                if (bus_stopped) begin
                    nxt_state = `ST_DEEP_SLEEP;
                end else if (bus_rise && bus_rst_ff) begin
                    if (rst_hold_ff == `RESET_HOLD_EDGES) begin
                        nxt_state      = `ST_NORMAL;
                        nxt_full_reset = 1'b1;
                        nxt_from_halt  = 1'b0;
                        nxt_rst_hold   = {`RESET_HOLD_W{1'b0}};
                    end else begin
                        nxt_rst_hold = rst_hold_ff + {{(`RESET_HOLD_W-1){1'b0}}, 1'b1};
                    end
                end else if (bus_rise) begin
                    nxt_rst_hold = {`RESET_HOLD_W{1'b0}};
                    if (!sleep_req_ff) begin
                        nxt_state = `ST_STOP_GRANT;
                    end
                end
            end
            `ST_DEEP_SLEEP: begin
                if (settle_done) begin
                    nxt_state    = `ST_SLEEP;
                    nxt_rst_hold = {`RESET_HOLD_W{1'b0}};
                end
            end
            default: begin
                // spare codes fall back to normal
                nxt_state = `ST_NORMAL;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // state and registered outputs
    // ------------------------------------------------------------------------
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_state                          <= `ST_NORMAL;
            from_halt_ff                     <= 1'b0;
            rst_hold_ff                      <= {`RESET_HOLD_W{1'b0}};
            o_full_reset                     <= 1'b0;
            o_bus_edge                       <= 1'b0;
            o_core_clk_en                    <= 1'b1;
            o_pll_lock_hold                  <= 1'b1;
            o_l2_clk_en                      <= 1'b1;
            o_snoop_en                       <= 1'b1;
            o_irq_latch_en                   <= 1'b1;
            o_interrupt_controller_clock_req <= 1'b1;
        end else begin
            o_state      <= nxt_state;
            from_halt_ff <= nxt_from_halt;
            rst_hold_ff  <= nxt_rst_hold;
            o_full_reset <= nxt_full_reset;
            o_bus_edge   <= bus_rise;
            o_core_clk_en <= (nxt_state == `ST_NORMAL);
            o_pll_lock_hold <= (nxt_state != `ST_DEEP_SLEEP);
            o_l2_clk_en <= (nxt_state != `ST_DEEP_SLEEP);
            o_snoop_en <= (nxt_state != `ST_SLEEP) && (nxt_state != `ST_DEEP_SLEEP);
            o_irq_latch_en <= (nxt_state != `ST_SLEEP) && (nxt_state != `ST_DEEP_SLEEP);
            o_interrupt_controller_clock_req <= (nxt_state != `ST_SLEEP) &&
                                                (nxt_state != `ST_DEEP_SLEEP);
        end
    end

    // ------------------------------------------------------------------------
    // pending interrupt latch
    // ------------------------------------------------------------------------
    // ignored while asleep
    // events are dropped, not held, while asleep; the chipset must
    // raise them again once the core is back in stop-grant
    assign irq_take = i_irq_event && !asleep;

    // set beats ack so an event landing on the clear cycle survives
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_pending <= 1'b0;
        end else if (irq_take) begin
            o_irq_pending <= 1'b1;
        end else if (i_irq_ack) begin
            o_irq_pending <= 1'b0;
        end
    end

endmodule // sleep_state_clock_control

`default_nettype wire

// ==== sim/chipset_model.sv ====
// chipset side: makes the bus clock and drives the power-management requests
// assumes commands from the bench are steady for many sample clocks
`timescale 1ns/10ps
`default_nettype none

module chipset_model (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    // bench commands
    input  wire logic i_clk_run,
    input  wire logic i_stop_cmd,
    input  wire logic i_sleep_cmd,
    input  wire logic i_reset_cmd,
    // pins toward the device
    output var  logic o_bus_clk,
    output var  logic o_sleep_request_n,
    output var  logic o_stop_clock_request_n,
    output var  logic o_bus_reset_n
);
    logic [1:0] div_ff;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_ff                 <= 2'h0;
            o_bus_clk              <= 1'b0;
            o_sleep_request_n      <= 1'b1;
            o_stop_clock_request_n <= 1'b1;
            o_bus_reset_n          <= 1'b1;
        end else begin
            // stop only at low level, restart together
            if (i_clk_run || o_bus_clk) begin
                div_ff <= div_ff + 2'h1;
                if (div_ff == 2'h3)
                    o_bus_clk <= ~o_bus_clk;
            end
            // pins move only at a bus rise, never while stopped
            if (div_ff == 2'h3 && !o_bus_clk && i_clk_run) begin
                o_bus_reset_n <= !i_reset_cmd;
                o_sleep_request_n      <= !(i_sleep_cmd && !i_reset_cmd);
                o_stop_clock_request_n <= !(i_stop_cmd && !i_reset_cmd);
            end
        end
    end
endmodule // chipset_model

`default_nettype wire

// ==== sim/sleep_state_checker.sv ====
// concurrent checks on the low-power state controller ports
// assumes the state codes of sleep_consts.vh and one sample clock
`timescale 1ns/10ps
`default_nettype none
`include "sleep_consts.vh"

module sleep_state_checker #(
    parameter [`SETTLE_W-1:0] SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input wire logic i_mclk, i_rst_n, i_bus_clk, i_sleep_request_n, i_stop_clock_request_n, i_bus_reset_n,
    input wire logic i_halt_exec, i_wake_event, i_irq_event, i_irq_ack, i_snoop_start, i_snoop_done,
    input wire logic [`ST_W-1:0] o_state,
    input wire logic o_core_clk_en, o_pll_lock_hold, o_l2_clk_en, o_snoop_en, o_irq_latch_en,
    input wire logic o_interrupt_controller_clock_req, o_irq_pending, o_full_reset, o_bus_edge
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    // time spent in deep sleep, to bound the settling wait
    logic [`SETTLE_W:0] deep_cnt_ff;
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            deep_cnt_ff <= '0;
        else if (o_state == `ST_DEEP_SLEEP)
            deep_cnt_ff <= deep_cnt_ff + 1'b1;
        else
            deep_cnt_ff <= '0;
    end

    a_state_legal:
        assert property (o_state <= `ST_DEEP_SLEEP) else $error("state code out of range");
    a_core_clk_gate:
        assert property (o_core_clk_en == (o_state == `ST_NORMAL)) else $error("core clock enable wrong");
    a_deep_clocks:
        assert property ((o_pll_lock_hold == (o_state != `ST_DEEP_SLEEP)) && (o_l2_clk_en == (o_state != `ST_DEEP_SLEEP)))
        else $error("l2 or pll enable wrong");
    a_asleep_deaf:
        assert property ((o_state == `ST_SLEEP || o_state == `ST_DEEP_SLEEP) |->
            !o_snoop_en && !o_irq_latch_en && !o_interrupt_controller_clock_req) else $error("awake while asleep");
    a_awake_snoop:
        assert property ((o_state == `ST_HALT || o_state == `ST_STOP_GRANT || o_state == `ST_SNOOP) |->
            o_l2_clk_en && o_snoop_en) else $error("l2 or snoop off while snoopable");
    a_sleep_source:
        assert property ((o_state == `ST_SLEEP && $past(o_state) != `ST_SLEEP) |->
            ($past(o_state) == `ST_STOP_GRANT || $past(o_state) == `ST_DEEP_SLEEP)) else $error("bad sleep entry");
    a_sleep_ignored:
        assert property ((o_state == `ST_NORMAL || o_state == `ST_HALT) |=> o_state != `ST_SLEEP)
        else $error("sleep taken from normal or halt");
    a_deep_source:
        assert property ((o_state == `ST_DEEP_SLEEP && $past(o_state) != `ST_DEEP_SLEEP) |->
            $past(o_state) == `ST_SLEEP) else $error("bad deep sleep entry");
    a_settle_wait:
        assert property ((o_state == `ST_SLEEP && $past(o_state) == `ST_DEEP_SLEEP) |->
            deep_cnt_ff >= SETTLE_CYCLES) else $error("deep sleep left too early");
    a_sleep_exit:
        assert property (($past(o_state) == `ST_SLEEP && o_state != `ST_SLEEP && o_state != `ST_DEEP_SLEEP) |->
            (o_state == `ST_STOP_GRANT || (o_state == `ST_NORMAL && o_full_reset))) else $error("bad sleep exit");
    a_snoop_source:
        assert property ((o_state == `ST_SNOOP && $past(o_state) != `ST_SNOOP) |->
            ($past(o_state) == `ST_HALT || $past(o_state) == `ST_STOP_GRANT)) else $error("bad snoop entry");
    a_grant_entry:
        assert property ((o_state == `ST_NORMAL && !i_stop_clock_request_n && i_bus_reset_n) |->
            ##[1:20] o_state != `ST_NORMAL) else $error("stop request not taken");
    a_grant_release:
        assert property ((o_state == `ST_STOP_GRANT && i_stop_clock_request_n && i_sleep_request_n && i_bus_reset_n
            && !i_snoop_start) |-> ##[1:20] o_state != `ST_STOP_GRANT) else $error("stop release not taken");
    a_bus_edge_pulse:
        assert property (o_bus_edge |-> ($past(i_bus_clk, 2) && !$past(i_bus_clk, 3)))
        else $error("bus edge pulse without a bus clock rise");
endmodule // sleep_state_checker

bind sleep_state_clock_control sleep_state_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sleep_chk (
    .i_mclk, .i_rst_n, .i_bus_clk, .i_sleep_request_n, .i_stop_clock_request_n, .i_bus_reset_n,
    .i_halt_exec, .i_wake_event, .i_irq_event, .i_irq_ack, .i_snoop_start, .i_snoop_done,
    .o_state, .o_core_clk_en, .o_pll_lock_hold, .o_l2_clk_en, .o_snoop_en, .o_irq_latch_en,
    .o_interrupt_controller_clock_req, .o_irq_pending, .o_full_reset, .o_bus_edge);

`default_nettype wire

// ==== sim/sleep_state_clock_control_tb_top.sv ====
// self-checking bench for the low-power state controller
// assumes chipset_model drives the bus side; inputs change at falling edges
`timescale 1ns/10ps
`default_nettype none
`include "sleep_consts.vh"

module sleep_state_clock_control_tb_top;
    // short settling wait keeps the run brief
    localparam [`SETTLE_W-1:0] SETTLE = 17'h14;
    typedef struct packed {logic stop; logic sleep; logic run; logic [2:0] st;} row_t;
    logic i_mclk = 0, i_rst_n = 0, run = 1, stop_cmd = 0, sleep_cmd = 0, reset_cmd = 0;
    logic halt = 0, wake = 0, irq = 0, ack = 0, snp_s = 0, snp_d = 0;
    logic bus_clk, sleep_n, stop_n, bus_rst_n, core_en, pll, l2, snp_en, irq_en, ic_req, pend, full_rst;
    logic [2:0] state;
    int n_mismatch = 0, compares = 0, cycles = 0;
    wire [11:0] obs = {3'h0, state, core_en, pll, l2, snp_en, irq_en, ic_req};
    row_t rows [8] = '{{3'h5, `ST_STOP_GRANT}, {3'h7, `ST_SLEEP}, {3'h6, `ST_DEEP_SLEEP}, {3'h7, `ST_SLEEP},
                       {3'h5, `ST_STOP_GRANT}, {3'h1, `ST_NORMAL}, {3'h3, `ST_NORMAL}, {3'h1, `ST_NORMAL}};

    always #4 i_mclk = ~i_mclk;

    chipset_model u_chipset (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_clk_run(run), .i_stop_cmd(stop_cmd),
        .i_sleep_cmd(sleep_cmd), .i_reset_cmd(reset_cmd), .o_bus_clk(bus_clk), .o_sleep_request_n(sleep_n),
        .o_stop_clock_request_n(stop_n), .o_bus_reset_n(bus_rst_n));

    sleep_state_clock_control #(.SETTLE_CYCLES(SETTLE)) DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_bus_clk(bus_clk), .i_sleep_request_n(sleep_n), .i_stop_clock_request_n(stop_n),
        .i_bus_reset_n(bus_rst_n), .i_halt_exec(halt), .i_wake_event(wake), .i_irq_event(irq), .i_irq_ack(ack),
        .i_snoop_start(snp_s), .i_snoop_done(snp_d), .o_state(state), .o_core_clk_en(core_en),
        .o_pll_lock_hold(pll), .o_l2_clk_en(l2), .o_snoop_en(snp_en), .o_irq_latch_en(irq_en),
        .o_interrupt_controller_clock_req(ic_req), .o_irq_pending(pend), .o_full_reset(full_rst), .o_bus_edge());

    function automatic logic [11:0] expv(input logic [2:0] s);
        logic asleep;
        asleep = (s == `ST_SLEEP) || (s == `ST_DEEP_SLEEP);
        return {3'h0, s, s == `ST_NORMAL, s != `ST_DEEP_SLEEP, s != `ST_DEEP_SLEEP, !asleep, !asleep, !asleep};
    endfunction

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wait_st(input logic [2:0] s, output int n);
        n = 0;
        while (state !== s && n < 400) begin
            @(negedge i_mclk);
            n++;
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge i_mclk);
    endtask

    task automatic tally_and_finish();
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // whole run needs about 500 cycles
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 10000) begin
            n_mismatch++;
            $display("MISMATCH t=%0t run did not complete", $time);
            tally_and_finish();
        end
    end

    initial begin
        int n;
        tick(3);
        check(obs, expv(`ST_NORMAL), "reset values");
        i_rst_n = 1;
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            {stop_cmd, sleep_cmd, run} = {rows[i].stop, rows[i].sleep, rows[i].run};
            wait_st(rows[i].st, n);
            if (i == 3) check({11'h0, n >= SETTLE}, 12'h001, "settling wait");
            tick(24);
            check(obs, expv(rows[i].st), "row state and enables");
            $display("test row %0d done", i);
        end
        halt = 1;
        tick(1);
        halt = 0;
        wait_st(`ST_HALT, n);
        sleep_cmd = 1;
        tick(24);
        check(obs, expv(`ST_HALT), "sleep request in halt");
        sleep_cmd = 0;
        snp_s = 1;
        wait_st(`ST_SNOOP, n);
        snp_s = 0;
        check(obs, expv(`ST_SNOOP), "snoop from halt");
        snp_d = 1;
        wait_st(`ST_HALT, n);
        snp_d = 0;
        check(obs, expv(`ST_HALT), "snoop done back to halt");
        wake = 1;
        tick(1);
        wake = 0;
        wait_st(`ST_NORMAL, n);
        irq = 1;
        tick(1);
        irq = 0;
        tick(1);
        check({11'h0, pend}, 12'h001, "interrupt latched when awake");
        ack = 1;
        tick(1);
        ack = 0;
        tick(1);
        check({11'h0, pend}, 12'h000, "interrupt acknowledged");
        $display("test halt snoop irq done");
        stop_cmd = 1;
        wait_st(`ST_STOP_GRANT, n);
        snp_s = 1;
        wait_st(`ST_SNOOP, n);
        snp_s = 0;
        snp_d = 1;
        wait_st(`ST_STOP_GRANT, n);
        snp_d = 0;
        check(obs, expv(`ST_STOP_GRANT), "snoop done back to stop-grant");
        sleep_cmd = 1;
        wait_st(`ST_SLEEP, n);
        irq = 1;
        tick(2);
        irq = 0;
        tick(1);
        check({11'h0, pend}, 12'h000, "interrupt ignored in sleep");
        {stop_cmd, sleep_cmd, reset_cmd} = 3'h1;
        n = 0;
        while (full_rst !== 1'b1 && n < 400) begin
            @(negedge i_mclk);
            n++;
        end
        check({8'h0, full_rst, state}, {8'h0, 1'b1, `ST_NORMAL}, "held reset in sleep");
        reset_cmd = 0;
        $display("test sleep reset done");
        stop_cmd = 1;
        wait_st(`ST_STOP_GRANT, n);
        i_rst_n = 0;
        tick(1);
        check(obs, expv(`ST_NORMAL), "reset in mid-run");
        stop_cmd = 0;
        i_rst_n = 1;
        tick(4);
        check(obs, expv(`ST_NORMAL), "after second reset");
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // sleep_state_clock_control_tb_top

`default_nettype wire
